/* rtl/cids_core.sv */
// Operation
// - compare-less-skip skips when file below working register, flags kept
// - taken skip runs nop cycles, two for a two-word instruction
// - decimal adjust adds 6 per nibble above 9 or carried
// - decrement-skip-zero writes destination, skips on zero result, flags kept
// - increment-skip-zero writes destination, skips on zero result, flags kept
// - increment-skip-nonzero writes destination, skips on nonzero result
// - absolute jump loads 20-bit literal into pc bits 20:1
// - absolute jump takes two cycles, second is a nop
// - bank bit 0 uses access bank, 1 uses bank select register
// - destination bit 0 writes working register, 1 writes file
`timescale 1ns/1ps
`default_nettype none
module cids_core
  import cids_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic [CIDS_IW-1:0] instr_in,
  input wire logic instr_valid_in,
  input wire logic [CIDS_IW-1:0] next_instr_in,
  input wire logic [7:0] bank_select_register_in,
  input wire logic [CIDS_DW-1:0] file_rdata_in,
  output logic [11:0] file_raddr_out,
  output cids_file_wr_t file_wr_out,
  output logic [CIDS_DW-1:0] working_register_out,
  output logic [4:0] flags_out,
  output logic [CIDS_PCW-1:0] pc_load_out,
  output logic pc_load_en_out,
  output logic nop_cycle_out,
  output logic instr_ready_out
);
  cids_state_t state_q;
  logic [7:0] working_register_q;
  logic [4:0] flags_q;
  cids_file_wr_t fwr_q;
  logic [CIDS_PCW-1:0] pcl_q;
  logic pcl_en_q;
  logic nop_q;
  logic [7:0] jlo_q;
  logic skip_two_q;

  logic [6:0] op7;
  logic [5:0] op6;
  logic dest_bit;
  logic [8:0] sum;
  logic [7:0] res;
  logic [7:0] daw_v;
  logic daw_c;
  logic is_cmp_lt, is_cmp_gt, is_daw, is_dec, is_decsz, is_decsnz;
  logic is_inc, is_incsz, is_incsnz, is_jump, is_arith;
  logic skip;
  logic next_two_word;
  logic go;
  logic [7:0] bank_sel;
  logic [7:0] lit_lo;
  logic [11:0] lit_hi;
  logic file_dest_go;

  assign op7 = instr_in[15:9];
  assign op6 = instr_in[15:10];
  assign dest_bit = instr_in[BIT_DEST];
  assign is_cmp_lt = op7 == OP_CMP_LESS;
  assign is_cmp_gt = op7 == OP_CMP_GREATER;
  assign is_daw = instr_in == OP_DEC_ADJ;
  assign is_dec = op6 == OP_DEC_FILE;
  assign is_decsz = op6 == OP_DEC_SKIP_Z;
  assign is_decsnz = op6 == OP_DEC_SKIP_NZ;
  assign is_inc = op6 == OP_INC_FILE;
  assign is_incsz = op6 == OP_INC_SKIP_Z;
  assign is_incsnz = op6 == OP_INC_SKIP_NZ;
  assign is_jump = instr_in[15:8] == OP_JUMP_HI;
  assign is_arith = is_dec | is_decsz | is_decsnz | is_inc | is_incsz |
    is_incsnz;
  assign go = clk_en_in && state_q == CIDS_EXEC && instr_valid_in;
  assign instr_ready_out = state_q == CIDS_EXEC;
  assign next_two_word = next_instr_in[15:12] == OP_SECOND_WORD;

  // bank bit 0 forces the access bank
  assign bank_sel = instr_in[BIT_BANK] ? bank_select_register_in
    : ACCESS_BANK;
  assign file_raddr_out = {bank_sel[3:0], instr_in[7:0]};

  // literal fields and write strobe seen by the checks
  assign lit_lo = instr_in[7:0];
  assign lit_hi = instr_in[11:0];
  assign file_dest_go = go && is_arith && dest_bit;

  always_comb begin
    if (is_inc | is_incsz | is_incsnz) begin
      sum = {1'b0, file_rdata_in} + 9'h001;
    end else begin
      sum = {1'b0, file_rdata_in} + 9'h0ff;
    end
    res = sum[7:0];
  end

  // decimal adjust, low then high nibble
  always_comb begin
    logic [4:0] lo;
    logic [4:0] hi;
    lo = {1'b0, working_register_q[3:0]};
    hi = {1'b0, working_register_q[7:4]};
    if (working_register_q[3:0] > BCD_LIMIT || flags_q[FL_DC]) begin
      lo = lo + {1'b0, BCD_FIX};
    end
    hi = hi + {4'h0, lo[4]};
    if (hi[3:0] > BCD_LIMIT || flags_q[FL_C] || hi[4]) begin
      hi = hi + {1'b0, BCD_FIX};
    end
    daw_v = {hi[3:0], lo[3:0]};
    daw_c = hi[4] | flags_q[FL_C];
  end

  always_comb begin
    skip = 1'b0;
    if (is_cmp_lt) begin
      skip = file_rdata_in < working_register_q;
    end else if (is_cmp_gt) begin
      skip = file_rdata_in > working_register_q;
    end else if (is_decsz) begin
      skip = res == 8'h00;
    end else if (is_incsz) begin
      skip = res == 8'h00;
    end else if (is_incsnz) begin
      skip = res != 8'h00;
    end else if (is_decsnz) begin
      skip = res != 8'h00;
    end
  end

  // sequencer for skip nops and jump second cycle
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_q <= CIDS_EXEC;
      skip_two_q <= 1'b0;
      nop_q <= 1'b0;
    end else if (clk_en_in) begin
      case (state_q)
        CIDS_EXEC: begin
          nop_q <= 1'b0;
          if (go && skip) begin
            state_q <= CIDS_SKIP;
            skip_two_q <= next_two_word;
          end else if (go && is_jump) begin
            state_q <= CIDS_JUMP2;
          end
        end
        CIDS_SKIP: begin
          nop_q <= 1'b1;
          skip_two_q <= 1'b0;
          if (!skip_two_q) begin
            state_q <= CIDS_EXEC;
          end
        end
        CIDS_JUMP2: begin
          nop_q <= 1'b1;
          state_q <= CIDS_EXEC;
        end
        default: begin
          state_q <= CIDS_EXEC;
        end
      endcase
    end
  end

  // jump target, pc bit 0 always zero
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pcl_q <= '0;
      pcl_en_q <= 1'b0;
      jlo_q <= 8'h00;
    end else if (clk_en_in) begin
      pcl_en_q <= 1'b0;
      if (go && is_jump) begin
        jlo_q <= instr_in[7:0];
      end
      if (state_q == CIDS_JUMP2) begin
        pcl_q <= {instr_in[11:0], jlo_q, 1'b0};
        pcl_en_q <= 1'b1;
      end
    end
  end

  // destination write and working register
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      working_register_q <= RST_WORKING_REGISTER;
      fwr_q <= '0;
    end else if (clk_en_in) begin
      fwr_q.we <= 1'b0;
      if (go && is_arith) begin
        if (dest_bit) begin
          fwr_q.we <= 1'b1;
          fwr_q.addr <= file_raddr_out;
          fwr_q.data <= res;
        end else begin
          working_register_q <= res;
        end
      end else if (go && is_daw) begin
        working_register_q <= daw_v;
      end
    end
  end

  // only plain inc/dec and decimal adjust touch flags
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      flags_q <= RST_FLAGS;
    end else if (clk_en_in) begin
      if (go && (is_inc || is_dec)) begin
        flags_q[FL_C] <= is_inc ? sum[8] : sum[8];
        flags_q[FL_DC] <= is_inc ? (file_rdata_in[3:0] == 4'hf)
          : (file_rdata_in[3:0] != 4'h0);
        flags_q[FL_Z] <= res == 8'h00;
        flags_q[FL_N] <= res[7];
        flags_q[FL_OV] <= is_inc ? (file_rdata_in == 8'h7f)
          : (file_rdata_in == 8'h80);
      end else if (go && is_daw) begin
        flags_q[FL_C] <= daw_c;
      end
    end
  end

  assign file_wr_out = fwr_q;
  assign working_register_out = working_register_q;
  assign flags_out = flags_q;
  assign pc_load_out = pcl_q;
  assign pc_load_en_out = pcl_en_q;
  assign nop_cycle_out = nop_q;

  AST_SKIP_NOP: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (go && skip && clk_en_in) ##1 clk_en_in |=> nop_q)
    else $error("skip did not give a nop cycle");
  AST_JUMP_PC: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (go && is_jump) ##1 clk_en_in |=> pcl_en_q && nop_q)
    else $error("jump did not load pc in second cycle");
  AST_JUMP_BIT0: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    pcl_en_q |-> pcl_q[0] == 1'b0)
    else $error("jump target bit 0 set");
  AST_CMP_FLAGS: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (go && is_cmp_lt) |=> $stable(flags_q))
    else $error("compare changed flags");
  AST_CMP_SKIP: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (go && is_cmp_lt && file_rdata_in >= working_register_q) |=> state_q == CIDS_EXEC)
    else $error("compare skipped wrongly");
  AST_DSZ_FLAGS: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (go && (is_decsz || is_incsz)) |=> $stable(flags_q))
    else $error("skip-zero changed flags");
  AST_ISZ_SKIP: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (go && is_incsz && file_rdata_in == 8'hff) |=> state_q == CIDS_SKIP)
    else $error("increment-skip-zero did not skip");
  AST_INZ_SKIP: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (go && is_incsnz && file_rdata_in == 8'hff) |=> state_q == CIDS_EXEC)
    else $error("increment-skip-nonzero skipped on zero");
  AST_DEST_FILE: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (go && is_arith && dest_bit) |=> fwr_q.we && $stable(working_register_q))
    else $error("file destination not written");
  AST_INC_Z: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (go && is_inc && file_rdata_in == 8'hff) |=> flags_q[FL_Z])
    else $error("increment zero flag wrong");
  AST_DSNZ: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (go && is_decsnz && file_rdata_in == 8'h01) |=> state_q == CIDS_EXEC)
    else $error("decrement-skip-nonzero skipped on zero");
  AST_BANK: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    !instr_in[BIT_BANK] |-> file_raddr_out[11:8] == 4'h0)
    else $error("access bank not used");

  // further checks on bank select, skips, writes, jump target, flags and freezing
  AST_BANK_SEL: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    instr_in[BIT_BANK] |->
      file_raddr_out[11:8] == bank_select_register_in[3:0])
    else $error("bank select register not used");
  AST_JUMP_TGT: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    pcl_en_q && $past(clk_en_in) && $past(clk_en_in, 2) |->
      pcl_q[20:9] == $past(lit_hi) && pcl_q[8:1] == $past(lit_lo, 2))
    else $error("jump target not built from both literal words");
  AST_FREEZE: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    !clk_en_in |=> $stable(working_register_q) && $stable(flags_q) &&
      $stable(state_q) && $stable(fwr_q) && $stable(pcl_q) && $stable(nop_q))
    else $error("state moved while clock enable low");
  AST_WE_PULSE: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    $past(clk_en_in) && fwr_q.we |-> $past(file_dest_go))
    else $error("file write without a file destination instruction");
  AST_SKIP_TWO: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (go && skip && next_two_word) ##1 clk_en_in |=> state_q == CIDS_SKIP)
    else $error("skip over two-word instruction too short");
  AST_SKIP_ONE: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (go && skip && !next_two_word) ##1 clk_en_in |=> state_q == CIDS_EXEC)
    else $error("skip over one-word instruction too long");
  AST_INZ_TAKEN: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (go && is_incsnz && file_rdata_in != 8'hff) |=> state_q == CIDS_SKIP)
    else $error("increment-skip-nonzero did not skip");
  AST_DSZ_TAKEN: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (go && is_decsz && file_rdata_in == 8'h01) |=> state_q == CIDS_SKIP)
    else $error("decrement-skip-zero did not skip");
  AST_CMP_TAKEN: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (go && is_cmp_lt && file_rdata_in < working_register_q) |=> state_q == CIDS_SKIP)
    else $error("compare did not skip");
  AST_DEST_W: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (go && is_arith && !dest_bit) |=> !fwr_q.we && working_register_q == $past(res))
    else $error("working register destination not written");
  AST_DAW_C: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (go && is_daw && flags_q[FL_C]) |=> flags_q[FL_C])
    else $error("decimal adjust dropped carry");
  AST_DEC_Z: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (go && is_dec && file_rdata_in == 8'h01) |=> flags_q[FL_Z])
    else $error("decrement zero flag wrong");

  COV_SKIP2: cover property (@(posedge clk_in)
    state_q == CIDS_SKIP && skip_two_q);
  COV_SKIP1: cover property (@(posedge clk_in)
    state_q == CIDS_SKIP && !skip_two_q);
  COV_JUMP: cover property (@(posedge clk_in) pcl_en_q);
  COV_DAW: cover property (@(posedge clk_in) go && is_daw);
  COV_FREEZE: cover property (@(posedge clk_in) !clk_en_in && instr_valid_in);
endmodule
`default_nettype wire

/* rtl/cids_pkg.sv */
package cids_pkg;
  localparam int CIDS_DW = 8;
  localparam int CIDS_IW = 16;
  localparam int CIDS_PCW = 21;
  // opcode match values, upper bits of the instruction word; decimal adjust matches the whole word
  localparam logic [6:0] OP_CMP_LESS = 7'h30;
  localparam logic [6:0] OP_CMP_GREATER = 7'h32;
  localparam logic [15:0] OP_DEC_ADJ = 16'h0007;
  localparam logic [5:0] OP_DEC_FILE = 6'h01;
  localparam logic [5:0] OP_DEC_SKIP_Z = 6'h0b;
  localparam logic [5:0] OP_DEC_SKIP_NZ = 6'h13;
  localparam logic [5:0] OP_INC_FILE = 6'h0a;
  localparam logic [5:0] OP_INC_SKIP_Z = 6'h0f;
  localparam logic [5:0] OP_INC_SKIP_NZ = 6'h12;
  localparam logic [7:0] OP_JUMP_HI = 8'hef;
  localparam logic [3:0] OP_SECOND_WORD = 4'hf;
  localparam int BIT_DEST = 9;
  localparam int BIT_BANK = 8;
  localparam logic [3:0] BCD_LIMIT = 4'h9;
  localparam logic [3:0] BCD_FIX = 4'h6;
  localparam logic [7:0] ACCESS_BANK = 8'h00;
  localparam logic [4:0] RST_FLAGS = 5'h00;
  localparam logic [7:0] RST_WORKING_REGISTER = 8'h00;
  // flag bit positions: c, dc, z, ov, n
  localparam int FL_C = 0;
  localparam int FL_DC = 1;
  localparam int FL_Z = 2;
  localparam int FL_OV = 3;
  localparam int FL_N = 4;
  typedef enum {CIDS_EXEC, CIDS_SKIP, CIDS_JUMP2} cids_state_t;
  typedef struct packed {
    logic we;
    logic [11:0] addr;
    logic [7:0] data;
  } cids_file_wr_t;
endpackage

/* tb/cids_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
  import cids_pkg::*;
;
  logic clk_in, sys_rst_in, clk_en_in, instr_valid_in;
  logic [15:0] instr_in, next_instr_in;
  logic [7:0] bank_select_register_in, file_rdata_in;
  logic [11:0] file_raddr_out, ra_seen;
  cids_file_wr_t file_wr_out;
  logic [7:0] working_register_out, w_exp;
  logic [4:0] flags_out, f_exp;
  logic [20:0] pc_load_out;
  logic pc_load_en_out, nop_cycle_out, instr_ready_out;
  int n_fail = 0;
  int checks = 0;
  int exp_gap = 0;
  logic nop_exp = 1'b0;
  logic [5:0] ops [6] = '{OP_INC_FILE, OP_DEC_FILE, OP_INC_SKIP_Z,
    OP_DEC_SKIP_Z, OP_INC_SKIP_NZ, OP_DEC_SKIP_NZ};
  logic [7:0] cor [5] = '{8'h00, 8'hff, 8'h7f, 8'h80, 8'h01};

  cids_core dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in), .instr_in(instr_in),
    .instr_valid_in(instr_valid_in), .next_instr_in(next_instr_in),
    .bank_select_register_in(bank_select_register_in),
    .file_rdata_in(file_rdata_in), .file_raddr_out(file_raddr_out),
    .file_wr_out(file_wr_out), .working_register_out(working_register_out),
    .flags_out(flags_out), .pc_load_out(pc_load_out),
    .pc_load_en_out(pc_load_en_out), .nop_cycle_out(nop_cycle_out),
    .instr_ready_out(instr_ready_out));

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  task automatic wrap_up;
    if (n_fail == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // k: 0 inc 1 dec 2 inc_skip_z 3 dec_skip_z 4 inc_skip_nz 5 dec_skip_nz
  // 6 cmp less 7 cmp greater
  function automatic void calc(input int k, input logic [7:0] r,
    output logic [7:0] res, output logic sk, output logic [4:0] fl);
    fl = f_exp;
    sk = 1'b0;
    res = (k % 2 == 1 && k < 6) ? r - 8'h01 : r + 8'h01;
    case (k)
      0: fl = {res[7], r == 8'h7f, res == 8'h00, r[3:0] == 4'hf, r == 8'hff};
      1: fl = {res[7], r == 8'h80, res == 8'h00, r[3:0] != 4'h0, r != 8'h00};
      2, 3: sk = (res == 8'h00);
      4, 5: sk = (res != 8'h00);
      6: sk = (r < w_exp);
      default: sk = (r > w_exp);
    endcase
  endfunction

  // called just after a rising edge; returns at the accepting edge
  task automatic run(input logic [15:0] i, input logic [15:0] nx,
    input logic [7:0] r, input logic [7:0] bs, input logic hold);
    int gap;
    instr_in <= i;
    next_instr_in <= nx;
    file_rdata_in <= r;
    bank_select_register_in <= bs;
    instr_valid_in <= 1'b1;
    gap = 0;
    @(negedge clk_in);
    while (instr_ready_out !== 1'b1 && gap < 8) begin
      gap++;
      @(negedge clk_in);
    end
    chk(21'(gap), 21'(exp_gap));
    exp_gap = 0;
    chk(21'(nop_cycle_out), 21'(nop_exp));
    nop_exp = 1'b0;
    ra_seen = file_raddr_out;
    @(posedge clk_in);
    instr_valid_in <= hold;
  endtask

  task automatic fop(input int k, input logic d, input logic a,
    input logic [7:0] f, input logic [7:0] r, input logic [7:0] bs,
    input logic [15:0] nx);
    logic [15:0] i;
    logic [7:0] res;
    logic sk;
    logic [4:0] fl;
    logic [11:0] ad;
    i = (k == 6) ? {OP_CMP_LESS, a, f} :
        (k == 7) ? {OP_CMP_GREATER, a, f} : {ops[k % 6], d, a, f};
    ad = {a ? bs[3:0] : 4'h0, f};
    calc(k, r, res, sk, fl);
    run(i, nx, r, bs, 1'b0);
    chk(ra_seen, ad);
    @(negedge clk_in);
    if (k < 6 && d) begin
      chk(file_wr_out.we, 1'b1);
      chk(file_wr_out.addr, ad);
      chk(file_wr_out.data, res);
    end else begin
      chk(file_wr_out.we, 1'b0);
      if (k < 6) w_exp = res;
      chk(working_register_out, w_exp);
    end
    chk(flags_out, fl);
    chk(instr_ready_out, !sk);
    f_exp = fl;
    exp_gap = (sk && nx[15:12] == OP_SECOND_WORD) ? 1 : 0;
    nop_exp = sk;
    @(posedge clk_in);
  endtask

  task automatic decimal_adjust_accum(input logic [7:0] e);
    run(OP_DEC_ADJ, 16'h0000, 8'h00, 8'h00, 1'b0);
    @(negedge clk_in);
    chk(working_register_out, e);
    chk(flags_out[FL_C], 1'b1);
    w_exp = e;
    f_exp[FL_C] = 1'b1;
    @(posedge clk_in);
  endtask

  // clock enable low: an offered instruction must not execute
  task automatic frz;
    clk_en_in <= 1'b0;
    instr_in <= {OP_INC_FILE, 1'b0, 1'b0, 8'h10};
    file_rdata_in <= 8'h7f;
    instr_valid_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    chk(working_register_out, w_exp);
    chk(flags_out, f_exp);
    chk(instr_ready_out, 1'b1);
    @(posedge clk_in);
    clk_en_in <= 1'b1;
    instr_valid_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic jmp(input logic [19:0] k);
    run({OP_JUMP_HI, k[7:0]}, 16'h0000, 8'h00, 8'h00, 1'b1);
    instr_in <= {OP_SECOND_WORD, k[19:8]};
    @(negedge clk_in);
    chk(instr_ready_out, 1'b0);
    chk(pc_load_en_out, 1'b0);
    @(posedge clk_in);
    instr_valid_in <= 1'b0;
    @(negedge clk_in);
    chk(pc_load_en_out, 1'b1);
    chk(pc_load_out, {k, 1'b0});
    chk(nop_cycle_out, 1'b1);
    @(posedge clk_in);
  endtask

  initial begin
    #2000000;
    n_fail++;
    wrap_up;
  end

  initial begin
    int k;
    logic [7:0] r;
    sys_rst_in = 1'b1;
    clk_en_in = 1'b1;
    instr_valid_in = 1'b0;
    instr_in = 16'h0000;
    next_instr_in = 16'h0000;
    bank_select_register_in = 8'h00;
    file_rdata_in = 8'h00;
    w_exp = RST_WORKING_REGISTER;
    f_exp = RST_FLAGS;
    void'($urandom(26));
    repeat (5) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(negedge clk_in);
    chk(working_register_out, RST_WORKING_REGISTER);
    chk(flags_out, RST_FLAGS);
    chk(instr_ready_out, 1'b1);
    @(posedge clk_in);
    fop(0, 1'b1, 1'b0, 8'h3c, 8'hff, 8'h05, 16'h0000);
    fop(0, 1'b1, 1'b1, 8'h21, 8'h10, 8'h03, 16'h0000);
    fop(2, 1'b0, 1'b1, 8'h20, 8'ha4, 8'h0a, 16'h0000);
    decimal_adjust_accum(8'h05);
    frz();
    fop(1, 1'b1, 1'b0, 8'h44, 8'h12, 8'h07, 16'h0000);
    fop(2, 1'b0, 1'b0, 8'h20, 8'hcd, 8'h00, 16'h0000);
    decimal_adjust_accum(8'h34);
    jmp(20'hfedcb);
    fop(3, 1'b1, 1'b1, 8'h80, 8'h01, 8'h0c, 16'hf123);
    jmp(20'h00001);
    fop(6, 1'b0, 1'b1, 8'h11, 8'h00, 8'h01, 16'hf000);
    for (int n = 0; n < 400; n++) begin
      k = $urandom % 8;
      r = ($urandom % 3 == 0) ? cor[$urandom % 5] : 8'($urandom);
      fop(k, 1'($urandom), 1'($urandom), 8'($urandom), r, 8'($urandom),
        {($urandom % 2) ? 4'hf : 4'h0, 12'($urandom)});
    end
    wrap_up;
  end
endmodule
`default_nettype wire
